/* bench/alu_props.sv */
`timescale 1ns/100ps
// ****
// ALU port checks
// ****
module alu_props (
  input logic       mclk,               // Clock
  input logic       rst,                // Reset
  input logic       start,              // Start
  input logic       busy,               // Busy
  input logic [3:0] op,                 // Opcode
  input logic       src_a,              // Dest select
  input logic       done,               // End
  input logic       wr_greg,            // Reg write
  input logic       wr_mem,             // Mem write
  input logic       skip_next,          // Skip
  input logic [3:0] program_status_word // Flags
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  wire [3:0] f  = program_status_word;
  wire [1:0] cz = program_status_word[2:1];
  sequence s_take(c); start && !busy && c; endsequence
  sequence s_end; ##3 done && !busy; endsequence
  a_busy_span: assert property (s_take(1'b1) |=> busy[*2] ##1 (done && !busy))
    else $error("busy span wrong");
  a_result_write: assert property (s_take((op <= 4'h6 || op == 4'hD) && !(op <= 4'h3 && f[3]))
    |-> ##3 (wr_greg != wr_mem) && (wr_mem == $past(src_a, 3)))
    else $error("write-back missing");
  a_cmp_nowrite: assert property (s_take(op <= 4'h3 && f[3]) |-> ##3 done && !wr_greg && !wr_mem)
    else $error("write under compare");
  a_eval_nowrite: assert property (s_take(op >= 4'h7 && op <= 4'hC) |-> s_end ##0 !wr_greg && !wr_mem)
    else $error("evaluation wrote");
  a_no_skip: assert property (s_take(op <= 4'h6 || op == 4'hD) |-> ##3 !skip_next)
    else $error("skip from non-evaluation");
  a_skip_done: assert property (skip_next |-> done)
    else $error("skip without end");
  a_bit_clears: assert property (s_take(op == 4'h7 || op == 4'h8) |-> ##3 !f[3])
    else $error("compare flag kept");
  a_logic_flags: assert property (s_take(op >= 4'h4 && op <= 4'h6) |-> ##3 cz == $past(cz, 3))
    else $error("logic changed flags");
  a_zero_sticky: assert property (s_take(op <= 4'h3 && f[3] && !f[1]) |-> ##3 !f[1])
    else $error("zero flag set");
endmodule // alu_props
bind nibble_alu alu_props chk (.mclk(mclk), .rst(rst), .start(start), .busy(busy), .op(op),
  .src_a(src_a), .done(done), .wr_greg(wr_greg), .wr_mem(wr_mem), .skip_next(skip_next),
  .program_status_word(program_status_word));

/* bench/nibble_alu_tb.sv */
`timescale 1ns/100ps
`include "nibble_alu_defines.vh"
`define CHK(n,e,g) begin cmp_count=cmp_count+1; if ((g)!==(e)) begin errors=errors+1; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
// ****
// ALU testbench
// ****
module nibble_alu_tb;
  reg        mclk, rst, start, src_a, src_b, psw_wr, sk;
  reg  [3:0] op, imm, psw_wdata;
  reg  [6:0] addr_a, addr_b, index_reg;
  wire [3:0] greg_rdata, mem_rdata_a, mem_rdata_b, wr_data, psw;
  wire [6:0] eff_addr_a, eff_addr_b, wr_addr;
  wire       wr_greg, wr_mem, skip_next, done, busy;
  integer    errors, cmp_count;
  reg [15:0] ev [0:7];
  nibble_alu uut (.mclk(mclk), .rst(rst), .start(start), .op(op), .src_a(src_a), .src_b(src_b),
    .addr_a(addr_a), .addr_b(addr_b), .greg_rdata(greg_rdata), .mem_rdata_a(mem_rdata_a),
    .mem_rdata_b(mem_rdata_b), .imm(imm), .index_reg(index_reg), .psw_wr(psw_wr),
    .psw_wdata(psw_wdata), .eff_addr_a(eff_addr_a), .eff_addr_b(eff_addr_b), .wr_data(wr_data),
    .wr_addr(wr_addr), .wr_greg(wr_greg), .wr_mem(wr_mem), .skip_next(skip_next), .done(done),
    .busy(busy), .program_status_word(psw));
  operand_store ptn (.mclk(mclk), .eff_addr_a(eff_addr_a), .eff_addr_b(eff_addr_b),
    .wr_addr(wr_addr), .wr_data(wr_data), .wr_greg(wr_greg), .wr_mem(wr_mem),
    .greg_rdata(greg_rdata), .mem_rdata_a(mem_rdata_a), .mem_rdata_b(mem_rdata_b));
  task conclude;
    begin
      $display("errors %0d comparisons %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask
  task set_psw(input [3:0] v);
    begin
      @(negedge mclk) {psw_wr, psw_wdata} = {1'b1, v};
      @(negedge mclk) psw_wr = 1'b0;
    end
  endtask
  task exec(input [3:0] o, input sa, input sb, input [6:0] aa, input [6:0] ab, input [3:0] im);
    integer n;
    begin
      @(negedge mclk) {op, src_a, src_b, addr_a, addr_b, imm, start} = {o, sa, sb, aa, ab, im, 1'b1};
      @(negedge mclk) start = 1'b0;
      for (n = 0; n < 8 && done !== 1'b1; n = n + 1) @(negedge mclk);
      sk = skip_next;
      `CHK("done", 1'b1, done)
      @(negedge mclk);
    end
  endtask
  function [4:0] exp_arith(input sub, input bcd, input integer r);
    integer v;
    begin
      if (!bcd || (r >= 0 && r <= 9)) v = r;
      else if ((!sub && r < 20) || (sub && r < 0 && r >= -10)) v = sub ? r + 10 : r - 10;
      else if (!sub) v = 48'hDCBADCFEDCFE >> (4 * (r - 20));
      else v = (r > 0 ? 24'hDCFEDC : 24'hFEDCFE) >> (4 * (r > 0 ? r - 10 : r + 16));
      exp_arith = {r < 0 || r > 15 || (bcd && r > 9), v[3:0]};
    end
  endfunction
  task t_arith(input sub, input bcd);
    integer k, r, a, b;
    reg [4:0] e;
    begin
      for (k = 0; k < 32; k = k + 1) begin
        r = sub ? k - 16 : k;
        a = (sub && r < 0) ? 0 : (r > 15 ? r - 16 : r);
        b = sub ? (r < 0 ? -r - 1 : 0) : (r > 15 ? 15 : 0);
        set_psw({1'b0, r < 0 || r > 15, 1'b0, bcd});
        ptn.greg[k] = a[3:0];
        exec(sub ? `OP_SUBC : `OP_ADDC, `SRC_A_GREG, `SRC_B_IMM, k[6:0], 7'h00, b[3:0]);
        e = exp_arith(sub, bcd, r);
        `CHK("result", e[3:0], ptn.greg[k])
        `CHK("flags", {1'b0, e[4], e[3:0] == 4'h0, bcd}, psw)
      end
    end
  endtask
  task t_compare_only;
    begin
      ptn.mem[16] = 4'h5;
      set_psw(4'hB);
      exec(`OP_SUB, `SRC_A_MEM, `SRC_B_IMM, 7'h10, 7'h00, 4'h5);
      `CHK("cmp_zero", 4'hB, psw)
      exec(`OP_ADD, `SRC_A_MEM, `SRC_B_IMM, 7'h10, 7'h00, 4'h8);
      `CHK("cmp_nonzero", 4'hD, psw)
      `CHK("cmp_mem", 4'h5, ptn.mem[16])
    end
  endtask
  task t_logic;
    integer i;
    reg [11:0] t;
    begin
      t = 12'h68E;
      set_psw(4'h7);
      ptn.mem[33] = 4'hA;
      for (i = 0; i < 3; i = i + 1) begin
        ptn.mem[32] = 4'hC;
        exec(4'h4 + i, `SRC_A_MEM, `SRC_B_MEM, 7'h20, 7'h21, 4'h0);
        `CHK("logic", t[4*i+:4], ptn.mem[32])
        `CHK("logic_flags", 4'h7, psw)
      end
    end
  endtask
  task t_eval;
    integer i;
    begin
      ev[0] = 16'h7B31; ev[1] = 16'h7B40; ev[2] = 16'h8B41; ev[3] = 16'h9551;
      ev[4] = 16'hA550; ev[5] = 16'hB551; ev[6] = 16'hC550; ev[7] = 16'hC451;
      set_psw(4'h8);
      for (i = 0; i < 8; i = i + 1) begin
        ptn.mem[48] = ev[i][11:8];
        exec(ev[i][15:12], `SRC_A_MEM, `SRC_B_IMM, 7'h30, 7'h00, ev[i][7:4]);
        `CHK("skip", ev[i][0], sk)
        `CHK("eval_mem", ev[i][11:8], ptn.mem[48])
        `CHK("eval_flags", 4'h0, psw)
      end
    end
  endtask
  task t_rotate;
    begin
      ptn.greg[3] = 4'h6;
      ptn.mem[0] = 4'hF;
      set_psw(4'h4);
      exec(`OP_ROTATE_RIGHT_THROUGH_CARRY, `SRC_A_GREG, `SRC_B_MEM, 7'h03, 7'h00, 4'hF);
      `CHK("rot1", 4'hB, ptn.greg[3])
      `CHK("rot1_cy", 4'h0, psw)
      exec(`OP_ROTATE_RIGHT_THROUGH_CARRY, `SRC_A_GREG, `SRC_B_MEM, 7'h03, 7'h00, 4'hF);
      `CHK("rot2", 4'h5, ptn.greg[3])
      `CHK("rot2_cy", 4'h4, psw)
    end
  endtask
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial begin
    #300000;
    errors = errors + 1;
    conclude;
  end
  initial begin
    {rst, start, src_a, src_b, psw_wr, op, imm, psw_wdata} = {1'b1, 17'h0};
    {addr_a, addr_b, index_reg, errors, cmp_count} = {14'h0, 7'h05, 64'h0};
    repeat (5) @(negedge mclk);
    rst = 1'b0;
    `CHK("psw_reset", 4'h0, psw)
    t_arith(1'b0, 1'b0);
    t_arith(1'b0, 1'b1);
    t_arith(1'b1, 1'b0);
    t_arith(1'b1, 1'b1);
    t_compare_only;
    t_logic;
    t_eval;
    t_rotate;
    conclude;
  end
endmodule // nibble_alu_tb

/* bench/operand_store.sv */
`timescale 1ns/100ps
// ****
// Register and memory model
// ****
module operand_store (
  input  wire       mclk,        // Clock
  input  wire [6:0] eff_addr_a,  // Read addr A
  input  wire [6:0] eff_addr_b,  // Read addr B
  input  wire [6:0] wr_addr,     // Write addr
  input  wire [3:0] wr_data,     // Write data
  input  wire       wr_greg,     // Reg write
  input  wire       wr_mem,      // Mem write
  output wire [3:0] greg_rdata,  // Reg data
  output wire [3:0] mem_rdata_a, // Mem data A
  output wire [3:0] mem_rdata_b  // Mem data B
);
  reg [3:0] greg [0:127];
  reg [3:0] mem  [0:127];
  integer   i;
  initial for (i = 0; i < 128; i = i + 1) begin
    greg[i] = 4'h0;
    mem[i] = 4'h0;
  end
  assign greg_rdata  = greg[eff_addr_a];
  assign mem_rdata_a = mem[eff_addr_a];
  assign mem_rdata_b = mem[eff_addr_b];
  always @(posedge mclk) begin
    if (wr_greg) greg[wr_addr] <= wr_data;
    if (wr_mem) mem[wr_addr] <= wr_data;
  end
endmodule // operand_store

/* src/bcd_correct.v */
`timescale 1ns/100ps
// ************************************************************
// Decimal correction stage
// ************************************************************
module bcd_correct (
  input  wire       is_sub,    // 1 for subtraction
  input  wire       raw_cy,    // Binary carry or borrow
  input  wire [3:0] raw_nib,   // Binary result nibble
  output reg  [3:0] cor_nib,   // Corrected nibble
  output reg        cor_cy     // Corrected carry
);
  always @* begin
    cor_nib = raw_nib;
    cor_cy  = raw_cy;
    if (!is_sub) begin
      if (!raw_cy && raw_nib <= 4'h9) begin
        cor_nib = raw_nib;
        cor_cy  = 1'b0;
      end else if (!raw_cy || raw_nib <= 4'h3) begin
        cor_nib = raw_nib + 4'h6;
        cor_cy  = 1'b1;
      end else begin
        cor_cy = 1'b1;
        case (raw_nib)
          4'hC:    cor_nib = 4'hA;
          4'hD:    cor_nib = 4'hB;
          default: cor_nib = {2'b11, ~raw_nib[1], raw_nib[0]};
        endcase
      end
    end else begin
      if (!raw_cy && raw_nib <= 4'h9) begin
        cor_nib = raw_nib;
        cor_cy  = 1'b0;
      end else if (raw_cy && raw_nib >= 4'h6) begin
        cor_nib = raw_nib - 4'h6;
        cor_cy  = 1'b1;
      end else begin
        cor_cy  = 1'b1;
        cor_nib = {2'b11, ~raw_nib[1], raw_nib[0]};
      end
    end
  end
endmodule // bcd_correct

/* src/nibble_alu.v */
`timescale 1ns/100ps
`include "nibble_alu_defines.vh"
// ************************************************************
// Nibble ALU datapath
// ************************************************************
module nibble_alu #(
  parameter AW = 7                           // Data memory address width
) (
  input  wire          mclk,                 // Core clock
  input  wire          rst,                  // Async reset, active high
  input  wire          start,                // One-cycle instruction start
  input  wire [3:0]    op,                   // Operation code
  input  wire          src_a,                // First operand source
  input  wire          src_b,                // Second operand source
  input  wire [AW-1:0] addr_a,               // First operand address
  input  wire [AW-1:0] addr_b,               // Second operand memory address
  input  wire [3:0]    greg_rdata,           // General register read data
  input  wire [3:0]    mem_rdata_a,          // Memory read data, first operand
  input  wire [3:0]    mem_rdata_b,          // Memory read data, second operand
  input  wire [3:0]    imm,                  // Immediate data or bit mask
  input  wire [AW-1:0] index_reg,            // Index register value
  input  wire          psw_wr,               // Direct flag write strobe
  input  wire [3:0]    psw_wdata,            // {cmp, cy, z, bcd}
  output wire [AW-1:0] eff_addr_a,           // First operand address; equals addr_a as index enable is never set
  output wire [AW-1:0] eff_addr_b,           // Second operand address; equals addr_b as index enable is never set
  output reg  [3:0]    wr_data,              // Write-back data
  output reg  [AW-1:0] wr_addr,              // Write-back address
  output reg           wr_greg,              // Write general register pulse
  output reg           wr_mem,               // Write data memory pulse
  output reg           skip_next,            // Skip next instruction pulse
  output reg           done,                 // Instruction end pulse
  output wire          busy,                 // Instruction in progress
  output wire [3:0]    program_status_word   // {cmp, cy, z, bcd}
);
  // ************************************************************
  // State machine and latches
  // ************************************************************
  localparam [2:0] ST_IDLE  = 3'b001;
  localparam [2:0] ST_LATCH = 3'b010;
  localparam [2:0] ST_EXEC  = 3'b100;

  reg [2:0]    state_q;
  reg [3:0]    op_a_q;
  reg [3:0]    op_b_q;
  reg [3:0]    op_q;
  reg          dst_q;
  reg [AW-1:0] addr_q;
  reg          compare_only_flag;
  reg          carry_flag;
  reg          zero_flag;
  reg          decimal_flag;
  reg          index_enable_flag;

  assign busy = ~state_q[0];
  assign program_status_word = {compare_only_flag, carry_flag, zero_flag, decimal_flag};

  function is_arith;
    input [3:0] o;
    begin
      is_arith = (o == `OP_ADD) || (o == `OP_ADDC) || (o == `OP_SUB) || (o == `OP_SUBC);
    end
  endfunction

  function is_judge;
    input [3:0] o;
    begin
      is_judge = (o == `OP_BTST1) || (o == `OP_BTST0) || (o == `OP_SKE) ||
                 (o == `OP_SKNE) || (o == `OP_SKGE) || (o == `OP_SKLT);
    end
  endfunction

  // Operand address mux; index enable is never set, so index_reg is not added
  assign eff_addr_a = index_enable_flag ? addr_a + index_reg : addr_a;
  assign eff_addr_b = index_enable_flag ? addr_b + index_reg : addr_b;

  // ************************************************************
  // Arithmetic core
  // ************************************************************
  wire       sub_op  = (op_q == `OP_SUB) || (op_q == `OP_SUBC) ||
                       (op_q == `OP_SKGE) || (op_q == `OP_SKLT);
  wire       cy_in   = ((op_q == `OP_ADDC) || (op_q == `OP_SUBC)) ? carry_flag : 1'b0;
  wire [4:0] sum5    = {1'b0, op_a_q} + {1'b0, op_b_q} + {4'h0, cy_in};
  wire [4:0] dif5    = {1'b0, op_a_q} - {1'b0, op_b_q} - {4'h0, cy_in};
  wire [4:0] raw5    = sub_op ? dif5 : sum5;
  wire [3:0] cor_nib;
  wire       cor_cy;

  bcd_correct u_bcd (
    .is_sub  (sub_op),
    .raw_cy  (raw5[4]),
    .raw_nib (raw5[3:0]),
    .cor_nib (cor_nib),
    .cor_cy  (cor_cy)
  );

  wire [3:0] ar_nib = decimal_flag ? cor_nib : raw5[3:0];
  wire       ar_cy  = decimal_flag ? cor_cy : raw5[4];

  // ************************************************************
  // Result and skip decision
  // ************************************************************
  reg [3:0] res;
  reg       skip_d;
  always @* begin
    res    = 4'h0;
    skip_d = 1'b0;
    case (op_q)
      `OP_ADD, `OP_ADDC, `OP_SUB, `OP_SUBC: res = ar_nib;
      `OP_OR:    res = op_a_q | op_b_q;
      `OP_AND:   res = op_a_q & op_b_q;
      `OP_XOR:   res = op_a_q ^ op_b_q;
      `OP_ROTATE_RIGHT_THROUGH_CARRY:  res = {carry_flag, op_a_q[3:1]};
      `OP_BTST1: skip_d = ((op_a_q & op_b_q) == op_b_q);
      `OP_BTST0: skip_d = ((op_a_q & op_b_q) == 4'h0);
      `OP_SKE:   skip_d = (op_a_q == op_b_q);
      `OP_SKNE:  skip_d = (op_a_q != op_b_q);
      `OP_SKGE:  skip_d = ~dif5[4];
      `OP_SKLT:  skip_d = dif5[4];
      default:   res = 4'h0;
    endcase
  end

  // ************************************************************
  // Sequencer
  // ************************************************************
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q           <= ST_IDLE;
      op_a_q            <= `RST_NIB;
      op_b_q            <= `RST_NIB;
      op_q              <= `RST_NIB;
      dst_q             <= `DST_GREG;
      addr_q            <= {AW{1'b0}};
      compare_only_flag <= 1'b0;
      carry_flag        <= 1'b0;
      zero_flag         <= 1'b0;
      decimal_flag      <= 1'b0;
      wr_data           <= `RST_NIB;
      wr_addr           <= {AW{1'b0}};
      wr_greg           <= 1'b0;
      wr_mem            <= 1'b0;
      skip_next         <= 1'b0;
      done              <= 1'b0;
    end else begin
      wr_greg   <= 1'b0;
      wr_mem    <= 1'b0;
      skip_next <= 1'b0;
      done      <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (psw_wr) begin
            {compare_only_flag, carry_flag, zero_flag, decimal_flag} <= psw_wdata;
          end
          if (start) begin
            op_q   <= op;
            addr_q <= eff_addr_a;
            dst_q  <= (op == `OP_ROTATE_RIGHT_THROUGH_CARRY) ? `DST_GREG : src_a;
            state_q <= ST_LATCH;
          end
        end
        ST_LATCH: begin
          op_a_q <= (op_q == `OP_ROTATE_RIGHT_THROUGH_CARRY || dst_q == `SRC_A_GREG) ?
                    greg_rdata : mem_rdata_a;
          op_b_q <= (src_b == `SRC_B_IMM) ? imm : mem_rdata_b;
          state_q <= ST_EXEC;
        end
        ST_EXEC: begin
          state_q <= ST_IDLE;
          done    <= 1'b1;
          if (is_arith(op_q)) begin
            carry_flag <= ar_cy;
            if (ar_nib != 4'h0) begin
              zero_flag <= 1'b0;
            end else if (!compare_only_flag) begin
              zero_flag <= 1'b1;
            end
          end else if (op_q == `OP_ROTATE_RIGHT_THROUGH_CARRY) begin
            carry_flag <= op_a_q[0];
          end
          if ((op_q == `OP_BTST1) || (op_q == `OP_BTST0)) begin
            compare_only_flag <= 1'b0;
          end
          if (is_judge(op_q)) begin
            skip_next <= skip_d;
          end else if (!(is_arith(op_q) && compare_only_flag)) begin
            wr_data <= res;
            wr_addr <= addr_q;
            wr_greg <= (dst_q == `DST_GREG);
            wr_mem  <= (dst_q == `DST_MEM);
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Index enable is cleared by reset and never set; a status port write leaves it unchanged
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      index_enable_flag <= 1'b0;
    end else if (psw_wr && state_q[0]) begin
      index_enable_flag <= index_enable_flag;
    end
  end
endmodule // nibble_alu

/* src/nibble_alu_defines.vh */
`ifndef NIBBLE_ALU_DEFINES_VH
`define NIBBLE_ALU_DEFINES_VH
// Operation codes
`define OP_ADD      4'h0
`define OP_ADDC     4'h1
`define OP_SUB      4'h2
`define OP_SUBC     4'h3
`define OP_OR       4'h4
`define OP_AND      4'h5
`define OP_XOR      4'h6
`define OP_BTST1    4'h7
`define OP_BTST0    4'h8
`define OP_SKE      4'h9
`define OP_SKNE     4'hA
`define OP_SKGE     4'hB
`define OP_SKLT     4'hC
`define OP_ROTATE_RIGHT_THROUGH_CARRY     4'hD
// Operand source selects
`define SRC_A_GREG  1'b0
`define SRC_A_MEM   1'b1
`define SRC_B_MEM   1'b0
`define SRC_B_IMM   1'b1
// Destination selects
`define DST_GREG    1'b0
`define DST_MEM     1'b1
// Reset values and decimal ten
`define RST_NIB     4'h0
`define RST_ADDR    7'h00
`define DEC_TEN     5'h0A
`endif
